// [logic/dbgcm_cfg.svh]
// offsets, field positions, reset values and widths of the comparator regs
`ifndef DBGCM_CFG_SVH
`define DBGCM_CFG_SVH

// register indexes; the byte address on the bus is four times the index
`define DBGCM_IDX_ADDR_HIGH 10'h029
`define DBGCM_IDX_ADDR_MID 10'h02A
`define DBGCM_IDX_ADDR_LOW 10'h02B
`define DBGCM_IDX_DATA_HIGH 10'h02C
`define DBGCM_IDX_DATA_LOW 10'h02D
`define DBGCM_IDX_DATA_HIGH_MASK 10'h02E
`define DBGCM_IDX_DATA_LOW_MASK 10'h02F
`define DBGCM_IDX_CTRL 10'h030
`define DBGCM_IDX_STATUS 10'h031
`define DBGCM_IDX_IRQ_MASK 10'h032

// control register fields
`define DBGCM_CTRL_VIEW_LSB 0
`define DBGCM_CTRL_ARMED_BIT 2
`define DBGCM_CTRL_TAG_A_BIT 3

// comparator view select codes
`define DBGCM_VIEW_A 2'h0
`define DBGCM_VIEW_NONE 2'h3

// reset values
`define DBGCM_RST_BYTE 8'h00
`define DBGCM_RST_ADDR_HIGH 2'h0
`define DBGCM_RST_FLAGS 3'h0
`define DBGCM_RST_WORD 32'h0000_0000

// ahb encodings
`define DBGCM_HTRANS_NONSEQ 2'h2
`define DBGCM_HSIZE_WORD 3'h2

`endif

// [logic/dbgcm_pkg.sv]
// types shared by the debug comparator match block
package dbgcm_pkg;
  typedef logic [7:0] dbgcm_byte_t;
  typedef logic [1:0] dbgcm_view_t;
  typedef logic [17:0] dbgcm_addr_t;
  typedef logic [15:0] dbgcm_data_t;
  typedef logic [9:0] dbgcm_idx_t;
  typedef logic [2:0] dbgcm_flags_t;
endpackage

// [logic/dbgcm_ahb_slave.sv]
// ahb-lite slave front end: zero wait state, single word transfers
`timescale 1ns/100ps
`include "dbgcm_cfg.svh"
module dbgcm_ahb_slave #(
  parameter int ADDR_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic rd_req,
  output dbgcm_pkg::dbgcm_idx_t rd_idx,
  output logic wr_req,
  output dbgcm_pkg::dbgcm_idx_t wr_idx
);
  logic take;
  logic wr_pend_q;
  logic wr_pend_d;
  dbgcm_pkg::dbgcm_idx_t wr_idx_q;
  dbgcm_pkg::dbgcm_idx_t wr_idx_d;
  logic ready_q;
  logic ready_d;

  // only whole-word accesses are decoded; others complete with no effect
  assign take = hsel && hready && (htrans == `DBGCM_HTRANS_NONSEQ) &&
                (hsize == `DBGCM_HSIZE_WORD);
  assign rd_req = take && !hwrite;
  assign rd_idx = haddr[11:2];
  assign wr_req = wr_pend_q;
  assign wr_idx = wr_idx_q;
  assign hreadyout = ready_q;
  assign hresp = 1'b0;

  // a write is held over to its data phase, where hwdata stands
  always_comb begin
    ready_d = 1'b1;
    wr_pend_d = take && hwrite;
    wr_idx_d = (take && hwrite) ? haddr[11:2] : wr_idx_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
    end else begin
      ready_q <= ready_d;
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
    end
  end
endmodule

// [logic/dbgcm_cmp.sv]
// one comparator: exact address match, optional masked data match
`timescale 1ns/100ps
module dbgcm_cmp #(
  parameter bit HAS_DATA = 1'b0
) (
  input wire dbgcm_pkg::dbgcm_addr_t sys_addr,
  input wire dbgcm_pkg::dbgcm_addr_t cmp_addr,
  input wire dbgcm_pkg::dbgcm_data_t sys_data,
  input wire dbgcm_pkg::dbgcm_data_t cmp_data,
  input wire dbgcm_pkg::dbgcm_data_t data_mask,
  input wire logic tag,
  output logic hit
);
  logic addr_ok;
  logic data_ok;

  // every compare bit demands zero when clear and one when set [R3]
  assign addr_ok = (sys_addr == cmp_addr); // [R1] [R2] [R13]
  // mask bit clear lets any data value through [R7] [R11]
  // tagged opcodes ignore data entirely [R9]
  assign data_ok = !HAS_DATA || tag ||
                   (((sys_data ^ cmp_data) & data_mask) == 16'h0000);
  assign hit = addr_ok && data_ok; // [R14]
endmodule

// [logic/dbgcm_top.sv]
// debug comparator compare registers with ahb-lite access and match logic
// Summary of operation
// R1: address bits 15..8 compared with selected comparator's mid register.
// R2: address bits 7..0 compared with selected comparator's low register.
// R3: compare bit clear expects address zero, set expects address one.
// R4: address mid and low always readable, writable only while not armed.
// R5: data-high register gives expected data bits 15..8.
// R6: data-low register gives expected data bits 7..0.
// R7: a data compare bit counts only when its mask bit is one.
// R8: data compare and mask exist only for comparator A.
// R9: data comparison only while comparator A tag select is clear.
// R10: data registers read with view 00, written with view 00 unarmed.
// R11: data-high mask clear lets any value match, set requires equality.
// R12: view select 00,01,10 picks comparator A,B,C; 11 picks none.
// R13: address-high register supplies expected address bits 17 and 16.
// R14: match needs all address bits and, for A untagged, masked data equal.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps
`include "dbgcm_cfg.svh"
module dbgcm_top #(
  parameter int ADDR_W = 12,
  parameter int NUM_CMP = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire dbgcm_pkg::dbgcm_addr_t sys_addr,
  input wire dbgcm_pkg::dbgcm_data_t sys_data,
  input wire logic sys_valid,
  output logic [NUM_CMP-1:0] cmp_match,
  output logic irq
);
  logic rd_req;
  dbgcm_pkg::dbgcm_idx_t rd_idx;
  logic wr_req;
  dbgcm_pkg::dbgcm_idx_t wr_idx;
  dbgcm_pkg::dbgcm_byte_t wbyte;

  // per comparator address storage
  logic [1:0] addr_high_q [NUM_CMP];
  logic [1:0] addr_high_d [NUM_CMP];
  dbgcm_pkg::dbgcm_byte_t addr_mid_q [NUM_CMP];
  dbgcm_pkg::dbgcm_byte_t addr_mid_d [NUM_CMP];
  dbgcm_pkg::dbgcm_byte_t addr_low_q [NUM_CMP];
  dbgcm_pkg::dbgcm_byte_t addr_low_d [NUM_CMP];

  // comparator A data storage only
  dbgcm_pkg::dbgcm_byte_t data_high_q;
  dbgcm_pkg::dbgcm_byte_t data_high_d;
  dbgcm_pkg::dbgcm_byte_t data_low_q;
  dbgcm_pkg::dbgcm_byte_t data_low_d;
  dbgcm_pkg::dbgcm_byte_t mask_high_q;
  dbgcm_pkg::dbgcm_byte_t mask_high_d;
  dbgcm_pkg::dbgcm_byte_t mask_low_q;
  dbgcm_pkg::dbgcm_byte_t mask_low_d;

  // control, status and interrupt state
  dbgcm_pkg::dbgcm_view_t view_q;
  dbgcm_pkg::dbgcm_view_t view_d;
  logic armed_q;
  logic armed_d;
  logic tag_a_q;
  logic tag_a_d;
  logic [NUM_CMP-1:0] status_q;
  logic [NUM_CMP-1:0] status_d;
  logic [NUM_CMP-1:0] irq_mask_q;
  logic [NUM_CMP-1:0] irq_mask_d;
  logic irq_q;
  logic irq_d;
  logic [NUM_CMP-1:0] match_q;
  logic [NUM_CMP-1:0] match_d;
  logic [NUM_CMP-1:0] hit;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  dbgcm_pkg::dbgcm_byte_t rd_byte;

  // write gates: locked while armed; view 11 reaches no comparator
  logic addr_wr_ok;
  logic data_wr_ok;

  assign wbyte = hwdata[7:0];
  assign addr_wr_ok = !armed_q && (view_q != `DBGCM_VIEW_NONE); // [R4] [R12]
  assign data_wr_ok = !armed_q && (view_q == `DBGCM_VIEW_A); // [R10]

  dbgcm_ahb_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .haddr(haddr),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_req(rd_req),
    .rd_idx(rd_idx),
    .wr_req(wr_req),
    .wr_idx(wr_idx)
  );

  // one comparator per channel; only channel 0 carries data storage
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    localparam bit HAS_DATA = (i == 0);
    dbgcm_cmp #(
      .HAS_DATA(HAS_DATA)
    ) u_cmp (
      .sys_addr(sys_addr),
      .cmp_addr({addr_high_q[i], addr_mid_q[i], addr_low_q[i]}),
      .sys_data(sys_data),
      .cmp_data(HAS_DATA ? {data_high_q, data_low_q} : 16'h0000), // [R5] [R6]
      .data_mask(HAS_DATA ? {mask_high_q, mask_low_q} : 16'h0000), // [R8]
      .tag(HAS_DATA ? tag_a_q : 1'b1),
      .hit(hit[i])
    );
  end

  // register writes land in the data phase of the bus transfer
  always_comb begin
    addr_high_d = addr_high_q;
    addr_mid_d = addr_mid_q;
    addr_low_d = addr_low_q;
    data_high_d = data_high_q;
    data_low_d = data_low_q;
    mask_high_d = mask_high_q;
    mask_low_d = mask_low_q;
    view_d = view_q;
    armed_d = armed_q;
    tag_a_d = tag_a_q;
    irq_mask_d = irq_mask_q;
    if (wr_req) begin
      case (wr_idx)
        `DBGCM_IDX_ADDR_HIGH: begin
          if (addr_wr_ok) begin
            addr_high_d[view_q] = wbyte[1:0]; // [R13]
          end
        end
        `DBGCM_IDX_ADDR_MID: begin
          if (addr_wr_ok) begin
            addr_mid_d[view_q] = wbyte; // [R1] [R4]
          end
        end
        `DBGCM_IDX_ADDR_LOW: begin
          if (addr_wr_ok) begin
            addr_low_d[view_q] = wbyte; // [R2] [R4]
          end
        end
        `DBGCM_IDX_DATA_HIGH: begin
          if (data_wr_ok) begin
            data_high_d = wbyte; // [R5] [R10]
          end
        end
        `DBGCM_IDX_DATA_LOW: begin
          if (data_wr_ok) begin
            data_low_d = wbyte; // [R6] [R10]
          end
        end
        `DBGCM_IDX_DATA_HIGH_MASK: begin
          if (data_wr_ok) begin
            mask_high_d = wbyte; // [R11] [R10]
          end
        end
        `DBGCM_IDX_DATA_LOW_MASK: begin
          if (data_wr_ok) begin
            mask_low_d = wbyte;
          end
        end
        `DBGCM_IDX_CTRL: begin
          view_d = wbyte[`DBGCM_CTRL_VIEW_LSB +: 2];
          armed_d = wbyte[`DBGCM_CTRL_ARMED_BIT];
          tag_a_d = wbyte[`DBGCM_CTRL_TAG_A_BIT]; // [R9]
        end
        `DBGCM_IDX_IRQ_MASK: begin
          irq_mask_d = wbyte[NUM_CMP-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < NUM_CMP; k++) begin
        addr_high_q[k] <= `DBGCM_RST_ADDR_HIGH;
        addr_mid_q[k] <= `DBGCM_RST_BYTE;
        addr_low_q[k] <= `DBGCM_RST_BYTE;
      end
      data_high_q <= `DBGCM_RST_BYTE;
      data_low_q <= `DBGCM_RST_BYTE;
      mask_high_q <= `DBGCM_RST_BYTE;
      mask_low_q <= `DBGCM_RST_BYTE;
      view_q <= `DBGCM_VIEW_A;
      armed_q <= 1'b0;
      tag_a_q <= 1'b0;
      irq_mask_q <= '0;
    end else begin
      addr_high_q <= addr_high_d;
      addr_mid_q <= addr_mid_d;
      addr_low_q <= addr_low_d;
      data_high_q <= data_high_d;
      data_low_q <= data_low_d;
      mask_high_q <= mask_high_d;
      mask_low_q <= mask_low_d;
      view_q <= view_d;
      armed_q <= armed_d;
      tag_a_q <= tag_a_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // match pulses and sticky status; a new match beats a same-cycle clear
  always_comb begin
    logic [NUM_CMP-1:0] clr;
    clr = '0;
    match_d = sys_valid ? hit : '0; // [R14]
    if (wr_req && (wr_idx == `DBGCM_IDX_STATUS)) begin
      clr = wbyte[NUM_CMP-1:0];
    end
    status_d = (status_q & ~clr) | (match_d & {NUM_CMP{armed_q}});
    irq_d = |(status_d & irq_mask_d);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_q <= '0;
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      match_q <= match_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  // read mux uses next values, so a read right behind a write sees it
  always_comb begin
    rd_byte = `DBGCM_RST_BYTE;
    case (rd_idx)
      `DBGCM_IDX_ADDR_HIGH: begin
        if (view_d != `DBGCM_VIEW_NONE) begin
          rd_byte = {6'h00, addr_high_d[view_d]}; // [R12]
        end
      end
      `DBGCM_IDX_ADDR_MID: begin
        if (view_d != `DBGCM_VIEW_NONE) begin
          rd_byte = addr_mid_d[view_d]; // [R4]
        end
      end
      `DBGCM_IDX_ADDR_LOW: begin
        if (view_d != `DBGCM_VIEW_NONE) begin
          rd_byte = addr_low_d[view_d]; // [R4]
        end
      end
      `DBGCM_IDX_DATA_HIGH: begin
        if (view_d == `DBGCM_VIEW_A) begin
          rd_byte = data_high_d; // [R10]
        end
      end
      `DBGCM_IDX_DATA_LOW: begin
        if (view_d == `DBGCM_VIEW_A) begin
          rd_byte = data_low_d; // [R10]
        end
      end
      `DBGCM_IDX_DATA_HIGH_MASK: begin
        if (view_d == `DBGCM_VIEW_A) begin
          rd_byte = mask_high_d; // [R10]
        end
      end
      `DBGCM_IDX_DATA_LOW_MASK: begin
        if (view_d == `DBGCM_VIEW_A) begin
          rd_byte = mask_low_d;
        end
      end
      `DBGCM_IDX_CTRL: begin
        rd_byte = {4'h0, tag_a_d, armed_d, view_d};
      end
      `DBGCM_IDX_STATUS: begin
        rd_byte = {5'h00, status_d};
      end
      `DBGCM_IDX_IRQ_MASK: begin
        rd_byte = {5'h00, irq_mask_d};
      end
      default: begin
      end
    endcase
    hrdata_d = rd_req ? {24'h00_0000, rd_byte} : hrdata_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `DBGCM_RST_WORD;
    end else begin
      hrdata_q <= hrdata_d;
    end
  end

  assign hrdata = hrdata_q;
  assign cmp_match = match_q;
  assign irq = irq_q;
endmodule

// [tb/dbgcm_checker.sv]
// port assertions for the debug comparator block
`timescale 1ns/100ps
module dbgcm_checker #(
  parameter int NUM_CMP = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire dbgcm_pkg::dbgcm_addr_t sys_addr,
  input wire dbgcm_pkg::dbgcm_data_t sys_data,
  input wire logic sys_valid,
  input wire logic [NUM_CMP-1:0] cmp_match,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // two valid cycles in a row, no register write landing in between
  sequence quiet_pair;
    sys_valid && $past(sys_valid) && !$past(hsel) && !$past(hsel, 2);
  endsequence
  a_idle_no_match: assert property (!sys_valid |=> cmp_match == '0)
    else $error("match without a valid bus cycle");
  a_addr_exact: assert property (
    quiet_pair and sys_addr != $past(sys_addr)
    |=> (cmp_match & $past(cmp_match)) == '0)
    else $error("match held across an address change");
  a_bc_no_data: assert property (
    quiet_pair and sys_addr == $past(sys_addr)
    |=> cmp_match[2:1] == $past(cmp_match[2:1]))
    else $error("comparator b or c depends on data");
  a_same_cycle: assert property (
    quiet_pair and sys_addr == $past(sys_addr) and sys_data == $past(sys_data)
    |=> cmp_match == $past(cmp_match))
    else $error("same bus cycle matched differently");
  a_irq_rise: assert property ($rose(irq) |-> $past(sys_valid) ||
    $past(sys_valid, 2) || $past(hsel, 2) || $past(hsel, 3))
    else $error("irq rose without a cause");
  a_irq_fall: assert property (
    $fell(irq) |-> $past(hsel, 2) || $past(hsel, 3))
    else $error("irq fell without a register write");
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  cover property (cmp_match[0]);
  cover property (cmp_match[2]);
  cover property ($rose(irq));
endmodule

// [tb/dbgcm_bus_model.sv]
// monitored cpu bus: one valid cycle per request cycle
`timescale 1ns/100ps
module dbgcm_bus_model (
  input wire logic hclk,
  input wire logic go,
  input wire dbgcm_pkg::dbgcm_addr_t a,
  input wire dbgcm_pkg::dbgcm_data_t d,
  output dbgcm_pkg::dbgcm_addr_t sys_addr,
  output dbgcm_pkg::dbgcm_data_t sys_data,
  output logic sys_valid
);
  initial begin
    sys_addr = 18'h0_0000;
    sys_data = 16'h0000;
  end
  // released lines flip each cycle so a stale value never looks valid
  always @(posedge hclk) begin
    sys_valid <= go;
    sys_addr <= go ? a : ~sys_addr;
    sys_data <= go ? d : ~sys_data;
  end
endmodule

// [tb/testbench.sv]
// self-checking bench for the comparator registers and match logic
`timescale 1ns/100ps
`include "dbgcm_cfg.svh"
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic hreadyout, hresp, irq, sys_valid;
  logic [2:0] cmp_match, m1, m2;
  dbgcm_pkg::dbgcm_addr_t a = 18'h0_0000, sys_addr;
  dbgcm_pkg::dbgcm_data_t d = 16'h0000, sys_data;
  int failures = 0, checked = 0;
  always #10 hclk = ~hclk;
  dbgcm_top u_dbgcm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sys_addr(sys_addr),
    .sys_data(sys_data), .sys_valid(sys_valid), .cmp_match(cmp_match),
    .irq(irq));
  dbgcm_bus_model u_dbgcm_bus_model (.hclk(hclk), .go(go), .a(a), .d(d),
    .sys_addr(sys_addr), .sys_data(sys_data), .sys_valid(sys_valid));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one single ahb transfer; read data is taken at the data phase edge
  task automatic xfer(input logic wr, input dbgcm_pkg::dbgcm_idx_t idx,
                      input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= `DBGCM_HTRANS_NONSEQ;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    hsize <= `DBGCM_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input dbgcm_pkg::dbgcm_idx_t idx, input logic [7:0] v);
    xfer(1'b1, idx, v);
  endtask
  task automatic rdc(input dbgcm_pkg::dbgcm_idx_t idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask
  // two back-to-back bus cycles; each match is seen one edge later
  task automatic pair(input dbgcm_pkg::dbgcm_addr_t a1, input
    dbgcm_pkg::dbgcm_addr_t a2, input logic [15:0] d1, input logic [15:0] d2);
    go <= 1'b1;
    a <= a1;
    d <= d1;
    @(posedge hclk);
    a <= a2;
    d <= d2;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    m1 = cmp_match;
    @(posedge hclk);
    m2 = cmp_match;
  endtask
  task automatic t_reset();
    for (int i = 'h29; i <= 'h2F; i++) begin
      rdc(10'(i), 8'h00);
    end
    rdc(10'h3FF, 8'h00);
  endtask
  task automatic t_view();
    wr(`DBGCM_IDX_ADDR_MID, 8'h12);
    wr(`DBGCM_IDX_ADDR_LOW, 8'h34);
    wr(`DBGCM_IDX_DATA_HIGH, 8'h56);
    wr(`DBGCM_IDX_DATA_HIGH_MASK, 8'hFF);
    wr(`DBGCM_IDX_CTRL, 8'h01);
    wr(`DBGCM_IDX_ADDR_MID, 8'h12);
    wr(`DBGCM_IDX_ADDR_LOW, 8'h35);
    rdc(`DBGCM_IDX_DATA_HIGH, 8'h00);
    wr(`DBGCM_IDX_CTRL, 8'h02);
    wr(`DBGCM_IDX_ADDR_MID, 8'hAB);
    wr(`DBGCM_IDX_ADDR_LOW, 8'hCD);
    rdc(`DBGCM_IDX_ADDR_LOW, 8'hCD);
    wr(`DBGCM_IDX_CTRL, 8'h03);
    wr(`DBGCM_IDX_ADDR_MID, 8'h77);
    rdc(`DBGCM_IDX_ADDR_MID, 8'h00);
    wr(`DBGCM_IDX_CTRL, 8'h01);
    rdc(`DBGCM_IDX_ADDR_LOW, 8'h35);
    wr(`DBGCM_IDX_CTRL, 8'h00);
    rdc(`DBGCM_IDX_ADDR_MID, 8'h12);
    rdc(`DBGCM_IDX_DATA_HIGH_MASK, 8'hFF);
  endtask
  task automatic t_match();
    pair(18'h0_1234, 18'h0_1234, 16'h56AA, 16'h5700);
    chk(m1, 3'h1);
    chk(m2, 3'h0);
    pair(18'h0_1235, 18'h1_1234, 16'h0000, 16'h5600);
    chk(m1, 3'h2);
    chk(m2, 3'h0);
    pair(18'h0_1235, 18'h0_1235, 16'h0000, 16'hFFFF);
    chk(m1, 3'h2);
    chk(m2, 3'h2);
    pair(18'h0_ABCD, 18'h0_1334, 16'h0000, 16'h5600);
    chk(m1, 3'h4);
    chk(m2, 3'h0);
    wr(`DBGCM_IDX_DATA_LOW, 8'h0A);
    wr(`DBGCM_IDX_DATA_LOW_MASK, 8'h0F);
    pair(18'h0_1234, 18'h0_1234, 16'h56FA, 16'h560B);
    chk(m1, 3'h1);
    chk(m2, 3'h0);
  endtask
  task automatic t_tag();
    wr(`DBGCM_IDX_CTRL, 8'h08);
    pair(18'h0_1234, 18'h0_1234, 16'h0000, 16'h0000);
    chk(m1, 3'h1);
    chk(m2, 3'h1);
    // address high bits must be stored per comparator, not tied low
    wr(`DBGCM_IDX_ADDR_HIGH, 8'h01);
    rdc(`DBGCM_IDX_ADDR_HIGH, 8'h01);
    pair(18'h1_1234, 18'h0_1234, 16'h0000, 16'h0000);
    chk(m1, 3'h1);
    chk(m2, 3'h0);
    wr(`DBGCM_IDX_ADDR_HIGH, 8'h00);
  endtask
  task automatic t_arm();
    wr(`DBGCM_IDX_CTRL, 8'h04);
    wr(`DBGCM_IDX_ADDR_MID, 8'h99);
    rdc(`DBGCM_IDX_ADDR_MID, 8'h12);
    wr(`DBGCM_IDX_DATA_HIGH, 8'h00);
    rdc(`DBGCM_IDX_DATA_HIGH, 8'h56);
    wr(`DBGCM_IDX_IRQ_MASK, 8'h01);
    pair(18'h0_1234, 18'h0_4321, 16'h560A, 16'h0000);
    chk(m1, 3'h1);
    chk(irq, 1'b1);
    rdc(`DBGCM_IDX_STATUS, 8'h01);
    wr(`DBGCM_IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    wr(`DBGCM_IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b1);
    wr(`DBGCM_IDX_STATUS, 8'h01);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
  endtask
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_view();
    t_match();
    t_tag();
    t_arm();
    conclude();
  end
  // whole run is about 130 cycles; this cuts a hung handshake
  initial begin
    #100000;
    failures++;
    conclude();
  end
endmodule
bind dbgcm_top dbgcm_checker #(.NUM_CMP(NUM_CMP)) u_dbgcm_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sys_addr(sys_addr),
  .sys_data(sys_data), .sys_valid(sys_valid), .cmp_match(cmp_match),
  .irq(irq));
